/* File: core/dlil_core.sv */
// instruction layer of a single-wire debug link: decode, pointer, repeat, responses
`timescale 1ns/1ps

// Notes on behaviour
// - indirect write with mode 2 loads its address bytes into the pointer
// - indirect write mode 0 writes at pointer, mode 1 also advances by data size
// - acknowledge is returned after the pointer has been loaded
// - acknowledge is returned after the system bus write completes
// - address and data operands reach up to 32 bits
// - control read takes its address from the opcode and returns one byte
// - control read byte goes out only after the guard idle time
// - control write stores one byte and sends nothing back
// - control write data byte may follow the instruction back to back
// - repeat counter holds values up to 255
// - instruction after the loop count runs count plus one times
// - only a break character stops a running repeat
// - repeated iterations run on operand or data frames alone
// - loop count op itself cannot be repeated
// - repeated indirect read streams, guard only before the first block
// - unlock takes only 64-bit codes, info block is at most 128 bits
// - size field sets the frame count, a received code gets no response
// - info block bytes go out after the configured guard time
// - each sync character emits one event pulse
// - guard inserts turnaround_idle_count idle bits of one bit time each
// - any error blocks all requests until a break arrives
module dlil_core
	import dlil_pkg::*;
#(
	parameter int TXB_DEPTH = 2,
	parameter int BITC_W    = 16
)(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// received characters from the serial layer
	input  wire dlil_rx_t             rx_i,
	// response bytes to the serial layer
	output logic                      tx_valid,
	output logic [7:0]                tx_data,
	input  wire logic                 tx_ready,
	// timing set by the sync character and the turnaround setting
	input  wire logic [BITC_W-1:0]    bit_cycles,
	input  wire logic [2:0]           turnaround_idle_count,
	// system bus
	output dlil_bus_req_t             bus_req,
	input  wire logic                 bus_ack,
	input  wire logic                 bus_err,
	input  wire logic [31:0]          bus_rdata,
	// control and status space
	output logic [CSA_W-1:0]          cs_addr,
	output logic                      cs_we,
	output logic [7:0]                cs_wdata,
	input  wire logic [7:0]           cs_rdata,
	// unlock code and information block
	output logic [63:0]               unlock_code,
	output logic                      unlock_vld,
	input  wire logic [127:0]         device_info_block,
	// status
	output logic                      sync_event,
	output logic                      link_error,
	output logic                      repeat_active
);

	// ==========================================================
	// elaboration checks
	if (TXB_DEPTH < 2 || (TXB_DEPTH & (TXB_DEPTH - 1)) != 0)
		$error("TXB_DEPTH must be a power of two of at least 2");
	if (BITC_W < 1)
		$error("BITC_W must be positive");

	localparam int PW = $clog2(TXB_DEPTH);

	// ==========================================================
	// state
	dlil_state_t     state_reg;
	logic [7:0]      op_reg;
	logic [2:0]      cnt_reg;
	logic [63:0]     rxw_reg;
	logic [31:0]     ptr_reg;
	logic [31:0]     addr_reg;
	logic [7:0]      rpt_reg;
	logic            rpt_act_reg;
	logic            sync_seen_reg;
	logic            ph_reg;
	logic            skip_gt_reg;
	logic [127:0]    txw_reg;
	logic [4:0]      txn_reg;
	logic [BITC_W-1:0] gcyc_reg;
	logic [2:0]      gbit_reg;
	logic            sync_evt_reg;

	// decode helpers
	logic [2:0]  opc;
	logic [1:0]  ptrm;
	logic [2:0]  n_a;
	logic [2:0]  n_b;
	logic [3:0]  need;
	logic        last;
	logic [63:0] rx_word;
	logic        fin;
	logic        guard_done;
	logic        push;
	logic        in_ready;

	assign opc = op_reg[OPC_LSB +: 3];
	assign ptrm = op_reg[PTR_LSB +: 2];
	// indirect ops size their pointer operand by the data size field
	assign n_a = {1'b0, opc[0] ? op_reg[SZB_LSB +: 2] : op_reg[SZA_LSB +: 2]} + 3'h1;
	assign n_b = {1'b0, op_reg[SZB_LSB +: 2]} + 3'h1;

	// byte count of the operand phase in progress
	always_comb
	begin
		need = 4'h1;
		if (state_reg == ST_OPER)
			need = {1'b0, n_a};
		else if (opc == OP_INDIR_WR || opc == OP_DIRECT_WR)
			need = {1'b0, n_b};
		else if (opc == OP_UNLOCK)
			need = KEY_BYTES[3:0];
	end
	assign last = ({1'b0, cnt_reg} == need - 4'h1);

	// operand word with the arriving byte placed by its index
	always_comb
	begin
		rx_word = rxw_reg;
		rx_word[cnt_reg*8 +: 8] = rx_i.data;
	end

	// where an iteration starts; also used for the first one
	function automatic dlil_state_t start_of(input logic [7:0] op);
		dlil_state_t s;
		case (op[OPC_LSB +: 3])
			OP_DIRECT_RD,
			OP_DIRECT_WR: s = ST_OPER;
			OP_INDIR_WR:  s = (op[PTR_LSB +: 2] == PTR_LOAD) ? ST_OPER : ST_DATA;
			OP_CTRL_WR,
			OP_LOOP_CNT:  s = ST_DATA;
			OP_UNLOCK:    s = op[KEY_SIB_B] ? ST_BUS : ST_DATA;
			default:      s = ST_BUS;
		endcase
		return s;
	endfunction

	// end of an instruction: last send byte or a silent write
	assign fin = (state_reg == ST_SEND && txn_reg == 5'h00 && !(opc == OP_DIRECT_WR && !ph_reg))
		|| (state_reg == ST_DATA && rx_i.byte_vld && last
			&& (opc == OP_CTRL_WR || opc == OP_UNLOCK));

	// ==========================================================
	// sync tracking and event output
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sync_evt_reg <= 1'b0;
		else
			sync_evt_reg <= rx_i.sync;
	end
	assign sync_event = sync_evt_reg;

	// ==========================================================
	// guard idle bits before the first response byte
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gcyc_reg <= '0;
			gbit_reg <= 3'h0;
		end
		else if (state_reg != ST_GUARD)
		begin
			gcyc_reg <= '0;
			gbit_reg <= 3'h0;
		end
		else if (gcyc_reg >= bit_cycles - BITC_W'(1))
		begin
			gcyc_reg <= '0;
			gbit_reg <= gbit_reg + 3'h1; // one idle bit per bit time
		end
		else
			gcyc_reg <= gcyc_reg + BITC_W'(1);
	end
	assign guard_done = (gbit_reg == turnaround_idle_count);

	// ==========================================================
	// instruction sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= ST_IDLE;
			op_reg        <= 8'h00;
			cnt_reg       <= 3'h0;
			rxw_reg       <= 64'h0;
			ptr_reg       <= PTR_RST;
			addr_reg      <= 32'h0;
			rpt_reg       <= RPT_RST;
			rpt_act_reg   <= 1'b0;
			sync_seen_reg <= 1'b0;
			ph_reg        <= 1'b0;
			skip_gt_reg   <= 1'b0;
			txw_reg       <= 128'h0;
			txn_reg       <= 5'h00;
			bus_req       <= '0;
			cs_addr       <= '0;
			cs_we         <= 1'b0;
			cs_wdata      <= 8'h00;
			unlock_code   <= 64'h0;
			unlock_vld    <= 1'b0;
		end
		else if (rx_i.brk)
		begin
			// break is the only exit from error and the only way to end a repeat before its count runs out
			state_reg     <= ST_IDLE;
			rpt_act_reg   <= 1'b0;
			rpt_reg       <= RPT_RST;
			sync_seen_reg <= 1'b0;
			skip_gt_reg   <= 1'b0;
			bus_req.valid <= 1'b0;
			cs_we         <= 1'b0;
			unlock_vld    <= 1'b0;
		end
		else if (rx_i.err || state_reg == ST_ERR)
		begin
			state_reg     <= ST_ERR;
			bus_req.valid <= 1'b0;
			cs_we         <= 1'b0;
			unlock_vld    <= 1'b0;
		end
		else
		begin
			cs_we      <= 1'b0;
			unlock_vld <= 1'b0;
			if (rx_i.sync)
				sync_seen_reg <= 1'b1;
			case (state_reg)
				ST_IDLE:
					if (rx_i.byte_vld)
					begin
						op_reg        <= rx_i.data;
						cnt_reg       <= 3'h0;
						ph_reg        <= 1'b0;
						sync_seen_reg <= 1'b0;
						cs_addr       <= rx_i.data[CSA_W-1:0];
						if (!sync_seen_reg)
							state_reg <= ST_ERR;
						else if (rx_i.data[OPC_LSB +: 3] == OP_LOOP_CNT && rpt_act_reg)
							state_reg <= ST_ERR;
						else if (rx_i.data[OPC_LSB +: 3] == OP_UNLOCK && !rx_i.data[KEY_SIB_B]
							&& rx_i.data[1:0] != KEY_SZ_64)
							state_reg <= ST_ERR;
						else
							state_reg <= start_of(rx_i.data);
					end
				ST_OPER:
					if (rx_i.byte_vld)
					begin
						rxw_reg <= rx_word;
						cnt_reg <= cnt_reg + 3'h1;
						if (last)
						begin
							if (opc == OP_INDIR_WR)
							begin
								ptr_reg   <= rx_word[31:0] & ({32{1'b1}} >> (8 * (4 - n_a)));
								txw_reg   <= {120'h0, ACK_CHAR};
								txn_reg   <= 5'h01;
								state_reg <= ST_GUARD;
							end
							else
							begin
								addr_reg  <= rx_word[31:0] & ({32{1'b1}} >> (8 * (4 - n_a)));
								txw_reg   <= {120'h0, ACK_CHAR};
								txn_reg   <= 5'h01;
								state_reg <= (opc == OP_DIRECT_WR) ? ST_GUARD : ST_BUS;
							end
						end
					end
				ST_DATA:
					if (rx_i.byte_vld)
					begin
						rxw_reg <= rx_word;
						cnt_reg <= cnt_reg + 3'h1;
						if (last)
						begin
							case (opc)
								OP_CTRL_WR:
								begin
									cs_we    <= 1'b1; // no response follows
									cs_wdata <= rx_i.data;
								end
								OP_LOOP_CNT:
								begin
									rpt_reg     <= rx_i.data;
									rpt_act_reg <= 1'b1;
									state_reg   <= ST_IDLE;
								end
								OP_UNLOCK:
								begin
									unlock_code <= rx_word; // silent
									unlock_vld  <= 1'b1;
								end
								default:
									state_reg <= ST_BUS;
							endcase
						end
					end
				ST_BUS:
				begin
					if (rx_i.byte_vld)
						state_reg <= ST_ERR; // byte during turnaround
					else if (opc == OP_CTRL_RD)
					begin
						txw_reg   <= {120'h0, cs_rdata}; // exactly one byte
						txn_reg   <= 5'h01;
						state_reg <= ST_GUARD;
					end
					else if (opc == OP_UNLOCK)
					begin
						txw_reg   <= device_info_block;
						txn_reg   <= (op_reg[1:0] == KEY_SZ_128) ? INFO_BYTES : KEY_BYTES;
						state_reg <= ST_GUARD;
					end
					else if (opc == OP_INDIR_RD && ptrm == PTR_LOAD)
					begin
						txw_reg   <= {96'h0, ptr_reg};
						txn_reg   <= {2'b00, n_a};
						state_reg <= ST_GUARD;
					end
					else if (!bus_req.valid)
					begin
						bus_req.valid <= 1'b1;
						bus_req.we    <= (opc == OP_INDIR_WR || opc == OP_DIRECT_WR);
						bus_req.size  <= op_reg[SZB_LSB +: 2];
						bus_req.addr  <= (opc[0]) ? ptr_reg : addr_reg;
						bus_req.wdata <= rxw_reg[31:0];
					end
					else if (bus_err)
					begin
						bus_req.valid <= 1'b0;
						state_reg     <= ST_ERR;
					end
					else if (bus_ack)
					begin
						bus_req.valid <= 1'b0;
						if (opc[0] && ptrm == PTR_AT_INC)
							ptr_reg <= ptr_reg + {29'h0, n_b};
						txw_reg   <= bus_req.we ? {120'h0, ACK_CHAR} : {96'h0, bus_rdata};
						txn_reg   <= bus_req.we ? 5'h01 : {2'b00, n_b};
						state_reg <= ST_GUARD;
					end
				end
				ST_GUARD:
					if (rx_i.byte_vld)
						state_reg <= ST_ERR;
					else if (skip_gt_reg || guard_done)
						state_reg <= ST_SEND;
				ST_SEND:
					if (rx_i.byte_vld)
						state_reg <= ST_ERR;
					else if (push)
					begin
						txw_reg <= txw_reg >> 8;
						txn_reg <= txn_reg - 5'h01;
					end
					else if (txn_reg == 5'h00)
					begin
						ph_reg    <= 1'b1;
						cnt_reg   <= 3'h0;
						state_reg <= ST_DATA; // direct write: address acked
					end
				default:
					state_reg <= ST_ERR;
			endcase
			// end of an instruction: run again while the counter allows
			if (fin)
			begin
				cnt_reg <= 3'h0;
				ph_reg  <= 1'b0;
				if (rpt_act_reg && rpt_reg != 8'h00)
				begin
					rpt_reg     <= rpt_reg - 8'h01; // count plus one runs
					state_reg   <= start_of(op_reg); // no sync, no opcode
					skip_gt_reg <= (opc == OP_INDIR_RD); // stream on
				end
				else
				begin
					rpt_act_reg <= 1'b0;
					skip_gt_reg <= 1'b0;
					state_reg   <= ST_IDLE;
				end
			end
		end
	end

	assign link_error = (state_reg == ST_ERR);
	assign repeat_active = rpt_act_reg;

	// ==========================================================
	// response buffer: stalls the sequencer when the serial side waits
	logic [7:0]  txb_mem [TXB_DEPTH];
	logic [PW:0] wp_reg;
	logic [PW:0] rp_reg;
	logic        full;
	logic        empty;

	assign full = (wp_reg[PW] != rp_reg[PW]) && (wp_reg[PW-1:0] == rp_reg[PW-1:0]);
	assign empty = (wp_reg == rp_reg);
	assign in_ready = !full;
	assign push = (state_reg == ST_SEND) && (txn_reg != 5'h00) && in_ready && !rx_i.byte_vld;
	assign tx_valid = !empty;
	assign tx_data = txb_mem[rp_reg[PW-1:0]];

	// buffer storage and pointers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			for (int i = 0; i < TXB_DEPTH; i++)
				txb_mem[i] <= 8'h00;
		end
		else
		begin
			if (push)
			begin
				txb_mem[wp_reg[PW-1:0]] <= txw_reg[7:0];
				wp_reg <= wp_reg + 1'b1;
			end
			if (tx_valid && tx_ready)
				rp_reg <= rp_reg + 1'b1;
		end
	end

	// ==========================================================
	// checks
	a_ptr_ack_after: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_OPER && rx_i.byte_vld && last && opc == OP_INDIR_WR && !rx_i.brk
			&& !rx_i.err) |=> (state_reg == ST_GUARD && txw_reg[7:0] == ACK_CHAR))
		else $error("pointer load not followed by acknowledge");

	a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_BUS && bus_req.valid && bus_ack && !bus_err && opc == OP_INDIR_WR
			&& !rx_i.brk && !rx_i.err && !rx_i.byte_vld)
		|=> ptr_reg == $past(ptr_reg) + {29'h0, $past(n_b)} * {31'h0, $past(ptrm) == PTR_AT_INC})
		else $error("pointer step wrong after indirect write");

	a_ctrl_wr_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(cs_we) |-> !tx_valid ##1 (state_reg != ST_GUARD && state_reg != ST_SEND))
		else $error("control write produced a response");

	a_ctrl_rd_one: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_BUS && opc == OP_CTRL_RD && !rx_i.brk && !rx_i.err && !rx_i.byte_vld)
		|=> txn_reg == 5'h01 ##1 state_reg != ST_SEND || txn_reg == 5'h01)
		else $error("control read byte count wrong");

	a_err_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(link_error && !rx_i.brk) |=> link_error && !push)
		else $error("error state left without break");

	a_break_stops: assert property (@(posedge clk) disable iff (!rst_n)
		rx_i.brk |=> (state_reg == ST_IDLE && !repeat_active && !bus_req.valid))
		else $error("break did not stop activity");

	a_sync_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		rx_i.sync |=> sync_event)
		else $error("sync character without event pulse");

	a_guard_wait: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_GUARD && !skip_gt_reg && !guard_done && !rx_i.brk && !rx_i.err
			&& !rx_i.byte_vld) |=> state_reg != ST_SEND)
		else $error("response sent before guard time");

	a_loop_load: assert property (@(posedge clk) disable iff (!rst_n)
		(state_reg == ST_DATA && opc == OP_LOOP_CNT && rx_i.byte_vld && !rx_i.brk && !rx_i.err)
		|=> (rpt_reg == $past(rx_i.data) && repeat_active))
		else $error("loop count not loaded");

	a_tx_held: assert property (@(posedge clk) disable iff (!rst_n)
		(tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data)))
		else $error("response byte changed while stalled");

endmodule

/* File: inc/dlil_pkg.sv */
// shared constants, types and states of the debug link instruction layer
package dlil_pkg;

	// ==========================================================
	// instruction byte layout
	localparam int OPC_LSB    = 5;
	localparam int PTR_LSB    = 2;
	localparam int SZA_LSB    = 2;
	localparam int SZB_LSB    = 0;
	localparam int KEY_SIB_B  = 2;
	localparam int CSA_W      = 4;

	// opcodes
	localparam logic [2:0] OP_DIRECT_RD  = 3'h0;
	localparam logic [2:0] OP_INDIR_RD   = 3'h1;
	localparam logic [2:0] OP_DIRECT_WR  = 3'h2;
	localparam logic [2:0] OP_INDIR_WR   = 3'h3;
	localparam logic [2:0] OP_CTRL_RD    = 3'h4;
	localparam logic [2:0] OP_LOOP_CNT   = 3'h5;
	localparam logic [2:0] OP_CTRL_WR    = 3'h6;
	localparam logic [2:0] OP_UNLOCK     = 3'h7;

	// indirect pointer modes
	localparam logic [1:0] PTR_AT        = 2'h0;
	localparam logic [1:0] PTR_AT_INC    = 2'h1;
	localparam logic [1:0] PTR_LOAD      = 2'h2;

	// unlock code sizes
	localparam logic [1:0] KEY_SZ_64     = 2'h0;
	localparam logic [1:0] KEY_SZ_128    = 2'h1;
	localparam logic [4:0] KEY_BYTES     = 5'h08;
	localparam logic [4:0] INFO_BYTES    = 5'h10;

	// response characters and reset values
	localparam logic [7:0]  ACK_CHAR     = 8'h40;
	localparam logic [31:0] PTR_RST      = 32'h0000_0000;
	localparam logic [7:0]  RPT_RST      = 8'h00;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dlil_bus_req_t;

	typedef struct packed {
		logic        byte_vld;
		logic [7:0]  data;
		logic        sync;
		logic        brk;
		logic        err;
	} dlil_rx_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_OPER  = 3'b001,
		ST_DATA  = 3'b010,
		ST_BUS   = 3'b011,
		ST_GUARD = 3'b100,
		ST_SEND  = 3'b101,
		ST_ERR   = 3'b110
	} dlil_state_t;

endpackage

/* File: dv/dlil_far_model.sv */
// far side model: system bus target, control space and response sink
`timescale 1ns/1ps
module dlil_far_model
	import dlil_pkg::*;
(
	// clock
	clk,
	// system bus target
	bus_req,
	bus_ack,
	bus_err,
	bus_rdata,
	// control and status space
	cs_addr,
	cs_we,
	cs_wdata,
	cs_rdata,
	// response sink
	tx_valid,
	tx_data,
	tx_ready
);
	input  wire logic             clk;
	input  wire dlil_bus_req_t    bus_req;
	output logic                  bus_ack;
	output logic                  bus_err;
	output logic [31:0]           bus_rdata;
	input  wire logic [CSA_W-1:0] cs_addr;
	input  wire logic             cs_we;
	input  wire logic [7:0]       cs_wdata;
	output logic [7:0]            cs_rdata;
	input  wire logic             tx_valid;
	input  wire logic [7:0]       tx_data;
	output logic                  tx_ready;

	logic [7:0]  csr [16];
	logic [31:0] cyc;
	int          wait_cnt;
	logic        slow;
	logic [7:0]  txq [$];
	logic [63:0] wq [$];

	// ==========================================================
	// start values
	initial
	begin
		cyc = 32'h0;
		bus_ack = 1'b0;
		bus_rdata = 32'h0;
		wait_cnt = 0;
		slow = 1'b0;
		for (int i = 0; i < 16; i++)
			csr[i] = 8'hFF;
	end
	// three-byte accesses answer with a fault alongside the acknowledge
	assign bus_err = bus_ack && bus_req.size == 2'h2;
	// control space read is combinational, one byte wide
	assign cs_rdata = csr[cs_addr];
	// the sink stalls one cycle in three
	assign tx_ready = (cyc % 3) != 0;

	// ==========================================================
	// bus answers alternate prompt and slow; idle read data keeps changing
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		bus_ack <= 1'b0;
		bus_rdata <= ~bus_rdata;
		if (cs_we)
			csr[cs_addr] <= cs_wdata;
		if (tx_valid && tx_ready)
			txq.push_back(tx_data);
		if (bus_req.valid && bus_ack && bus_req.we)
			wq.push_back({22'h0, bus_req.size, bus_req.addr, bus_req.wdata[7:0]});
		if (bus_req.valid && !bus_ack)
		begin
			if (wait_cnt >= (slow ? 4 : 0))
			begin
				bus_ack <= 1'b1;
				bus_rdata <= bus_req.addr ^ 32'hA5A5_5A5A;
				slow <= !slow;
				wait_cnt <= 0;
			end
			else
				wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

/* File: dv/testbench.sv */
// self-checking bench of the instruction layer against a queue model
`timescale 1ns/1ps
module testbench
	import dlil_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, tx_valid, tx_ready, bus_ack, bus_err, cs_we, unlock_vld;
	logic sync_event, link_error, repeat_active;
	dlil_rx_t rx_i;
	dlil_bus_req_t bus_req;
	logic [7:0] tx_data, cs_wdata, cs_rdata;
	logic [15:0] bit_cycles;
	logic [2:0] idle_bits;
	logic [31:0] bus_rdata, ptr, r, seed = 32'h0000_0053;
	logic [CSA_W-1:0] cs_addr;
	logic [63:0] unlock_code, key;
	logic [127:0] info;
	logic [7:0] exp_tx [$];
	int mismatches = 0, n_tests = 0, cyc = 0, k;

	dlil_core uut (.clk(clk), .rst_n(rst_n), .rx_i(rx_i), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .bit_cycles(bit_cycles),
		.turnaround_idle_count(idle_bits), .bus_req(bus_req), .bus_ack(bus_ack),
		.bus_err(bus_err), .bus_rdata(bus_rdata), .cs_addr(cs_addr), .cs_we(cs_we),
		.cs_wdata(cs_wdata), .cs_rdata(cs_rdata), .unlock_code(unlock_code),
		.unlock_vld(unlock_vld), .device_info_block(info), .sync_event(sync_event),
		.link_error(link_error), .repeat_active(repeat_active));
	dlil_far_model far (.clk(clk), .bus_req(bus_req), .bus_ack(bus_ack), .bus_err(bus_err),
		.bus_rdata(bus_rdata), .cs_addr(cs_addr), .cs_we(cs_we), .cs_wdata(cs_wdata),
		.cs_rdata(cs_rdata), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// ==========================================================
	// clock, hang guard and helpers
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			mismatches++;
			final_report();
		end
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic drv(input dlil_rx_t v);
		@(posedge clk);
		rx_i <= v;
	endtask
	task automatic sb(input logic [7:0] b);
		drv('{1'b1, b, 1'b0, 1'b0, 1'b0});
		drv('0);
	endtask
	task automatic sync_i(input logic [7:0] b);
		drv('{1'b0, 8'h00, 1'b1, 1'b0, 1'b0});
		drv('0);
		sb(b);
	endtask
	task automatic brk();
		drv('{1'b0, 8'h00, 1'b0, 1'b1, 1'b0});
		drv('0);
		repeat (2) @(posedge clk);
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 400 && far.txq.size() < n; i++)
			@(posedge clk);
	endtask
	// responses seen by the sink against the model queue
	task automatic chk_tx();
		chk(64'(far.txq.size()), 64'(exp_tx.size()));
		while (exp_tx.size() > 0 && far.txq.size() > 0)
			chk(64'(far.txq.pop_front()), 64'(exp_tx.pop_front()));
		exp_tx.delete();
		far.txq.delete();
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		rx_i = '0;
		bit_cycles = 16'h0003;
		idle_bits = 3'h2;
		info = {xs(), xs(), xs(), xs()};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// control write, data byte back to back with the instruction
		r = xs();
		drv('{1'b0, 8'h00, 1'b1, 1'b0, 1'b0});
		drv('0);
		#1 chk(64'(sync_event), 64'h1);
		drv('{1'b1, 8'hC2, 1'b0, 1'b0, 1'b0});
		drv('{1'b1, r[7:0], 1'b0, 1'b0, 1'b0});
		drv('0);
		for (k = 0; k < 6 && cs_we !== 1'b1; k++)
			@(posedge clk);
		chk({cs_we, cs_addr, cs_wdata}, {1'b1, 4'h2, r[7:0]});
		repeat (20) @(posedge clk);
		chk(64'(far.txq.size()), 64'h0);
		$display("test control write done");
		// control read after the guard idle bits
		sync_i(8'h82);
		for (k = 0; k < 100 && tx_valid !== 1'b1; k++)
			@(posedge clk);
		chk(64'(k >= 6), 64'h1);
		exp_tx.push_back(r[7:0]);
		wait_tx(1);
		chk_tx();
		$display("test control read done");
		// pointer load with a four byte address
		ptr = xs();
		sync_i(8'h6B);
		for (int i = 0; i < 4; i++)
			sb(ptr[8*i+:8]);
		exp_tx.push_back(ACK_CHAR);
		wait_tx(1);
		chk_tx();
		chk(64'(far.wq.size()), 64'h0);
		$display("test pointer load done");
		// repeat count 2: post-increment writes, each frame followed by its ack
		sync_i(8'hA0);
		sb(8'h02);
		sync_i(8'h64);
		for (int i = 0; i < 3; i++)
		begin
			r = xs();
			sb(r[7:0]);
			exp_tx.push_back(ACK_CHAR);
			wait_tx(1);
			chk_tx();
			chk(far.wq.pop_front(), {24'h0, ptr + 32'(i), r[7:0]});
		end
		repeat (20) @(posedge clk);
		chk({32'(far.wq.size()), 31'h0, repeat_active}, 64'h0);
		$display("test repeated write done");
		// repeat of 3 stopped by a break after one frame at the pointer
		sync_i(8'hA0);
		sb(8'h03);
		sync_i(8'h60);
		r = xs();
		sb(r[7:0]);
		exp_tx.push_back(ACK_CHAR);
		wait_tx(1);
		chk_tx();
		chk(far.wq.pop_front(), {24'h0, ptr + 32'h3, r[7:0]});
		chk(64'(repeat_active), 64'h1);
		brk();
		chk({link_error, repeat_active}, 64'h0);
		$display("test repeat break done");
		// repeated indirect read streams, then the pointer is read back
		sync_i(8'hA0);
		sb(8'h02);
		sync_i(8'h24);
		for (int i = 3; i < 6; i++)
			exp_tx.push_back(8'(ptr + 32'(i)) ^ 8'h5A);
		wait_tx(3);
		chk_tx();
		sync_i(8'h3B);
		for (int i = 0; i < 4; i++)
			exp_tx.push_back(8'((ptr + 32'h6) >> (8 * i)));
		wait_tx(4);
		chk_tx();
		// direct accesses carry their address every iteration
		sync_i(8'hA0);
		sb(8'h01);
		sync_i(8'h00);
		for (int i = 0; i < 2; i++)
		begin
			r = xs();
			sb(r[7:0]);
			exp_tx.push_back(r[7:0] ^ 8'h5A);
			wait_tx(1);
			chk_tx();
		end
		r = xs();
		sync_i(8'h40);
		sb(r[7:0]);
		exp_tx.push_back(ACK_CHAR);
		wait_tx(1);
		chk_tx();
		sb(r[15:8]);
		exp_tx.push_back(ACK_CHAR);
		wait_tx(1);
		chk_tx();
		chk(far.wq.pop_front(), {56'(r[7:0]), r[15:8]});
		$display("test direct access done");
		// instruction without sync locks the link until a break
		sb(8'h82);
		sync_i(8'h82);
		repeat (40) @(posedge clk);
		chk({far.txq.size(), 31'h0, link_error}, 64'h1);
		brk();
		chk(64'(link_error), 64'h0);
		// a loop count under an active repeat is refused
		sync_i(8'hA0);
		sb(8'h01);
		sync_i(8'hA0);
		repeat (4) @(posedge clk);
		chk(64'(link_error), 64'h1);
		brk();
		// a bus fault locks the link as well
		sync_i(8'h02);
		sb(8'h10);
		repeat (20) @(posedge clk);
		chk(64'(link_error), 64'h1);
		brk();
		$display("test error lock done");
		// key of eight bytes, no response
		key = {xs(), xs()};
		sync_i(8'hE0);
		for (int i = 0; i < 8; i++)
			sb(key[8*i+:8]);
		for (k = 0; k < 20 && unlock_vld !== 1'b1; k++)
			@(posedge clk);
		chk({unlock_vld, unlock_code}, {1'b1, key});
		repeat (30) @(posedge clk);
		chk(64'(far.txq.size()), 64'h0);
		// sixteen byte information readout after the guard time
		sync_i(8'hE5);
		for (int i = 0; i < 16; i++)
			exp_tx.push_back(info[8*i+:8]);
		wait_tx(16);
		chk_tx();
		$display("test key and info done");
		final_report();
	end
endmodule
